// ===== src/extended_disk_command_unit.sv
`timescale 1ns/1ps
`default_nettype none
module extended_disk_command_unit
  import edcu_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // switches and drive status pins
  input wire logic [7:0] config_switch_bank,
  input wire logic [1:0] unit_write_protect,
  // header read channel from the drives
  input wire logic index_pulse,
  input wire logic hdr_rd_strobe,
  input wire logic [DATA_W-1:0] hdr_rd_data,
  // header write channel and addressing to the drives
  output logic hdr_wr_en,
  output logic [DATA_W-1:0] hdr_wr_data,
  output logic [DATA_W-1:0] seek_cylinder,
  output logic [TRK_MSB:0] seek_track,
  output logic unit_select,
  // status
  output logic [7:0] drive_protected,
  output logic cmd_busy
);
  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  localparam int PINS = 28;
  logic [PINS-1:0] pin_meta;
  logic [PINS-1:0] pin_s;
  logic idx_d;
  logic stb_d;
  logic idx_s;
  logic stb_s;
  logic [1:0] wp_s;
  logic [7:0] bank_s;
  logic [DATA_W-1:0] hdr_s;
  logic idx_edge;
  logic stb_edge;

  // two stages for every pin; edges are taken from the second stage only
  always_ff @(posedge core_clk) begin
    pin_meta <= {index_pulse, hdr_rd_strobe, unit_write_protect,
                 config_switch_bank, hdr_rd_data};
    pin_s <= pin_meta;
  end
  assign {idx_s, stb_s, wp_s, bank_s, hdr_s} = pin_s;

  // edge history
  always_ff @(posedge core_clk) begin
    if (srst) begin
      idx_d <= 1'b0;
      stb_d <= 1'b0;
    end else begin
      idx_d <= idx_s;
      stb_d <= stb_s;
    end
  end
  assign idx_edge = idx_s && !idx_d;
  assign stb_edge = stb_s && !stb_d;

  ////////////////////////////////////////////////////////////////////////
  // configuration and silo
  logic [7:0] present;
  logic [7:0] on_unit1;
  logic [5:0] sec_unit0;
  logic [5:0] sec_unit1;

  // drive layout follows the switch bank
  drive_config_map u_map (
    .bank(bank_s),
    .present(present),
    .on_unit1(on_unit1),
    .sec_unit0(sec_unit0),
    .sec_unit1(sec_unit1)
  );

  silo_if #(.W(DATA_W), .CW(9)) silo ();
  silo_store #(.DEPTH(SILO_DEPTH), .W(DATA_W)) u_silo (
    .core_clk(core_clk),
    .srst(srst),
    .s(silo)
  );

  ////////////////////////////////////////////////////////////////////////
  // software registers
  state_t state;
  logic [DATA_W-1:0] desired_cylinder_reg;
  logic [DATA_W-1:0] disk_track_sector_reg;
  logic [DATA_W-1:0] spare;
  logic [DATA_W-1:0] maint_reg_three;
  logic [4:0] cmd_fn;
  logic cmd_unit;
  logic illegal_function_err;
  logic search_err;
  logic ext_en;
  logic [7:0] lock;
  logic [5:0] switch_reg;
  logic wr_cmd;
  logic cmd_start;
  logic ctl_clr;
  logic is_ext;
  logic run_ext;
  logic run_wp;
  logic [4:0] wfn;

  assign wfn = reg_wdata[CMD_FN_MSB:CMD_FN_LSB];
  assign wr_cmd = reg_wr && (reg_addr == REG_CMD);
  assign cmd_start = wr_cmd && reg_wdata[CMD_GO_BIT] && (state == ST_IDLE);
  assign ctl_clr = reg_wr && (reg_addr == REG_CTRL) &&
                   reg_wdata[CTRL_CLR_BIT];
  assign is_ext = (wfn == FN_WRITE_PROTECT) ||
                  (wfn == FN_READ_UNIT_HDR) || (wfn == FN_WRITE_UNIT_HDR);
  assign run_ext = cmd_start && is_ext && ext_en;
  assign run_wp = run_ext && (wfn == FN_WRITE_PROTECT);
  assign cmd_busy = (state != ST_IDLE);

  // plain storage registers; the cylinder and track feed the drive address
  always_ff @(posedge core_clk) begin
    if (srst) begin
      desired_cylinder_reg <= RST_WORD;
      disk_track_sector_reg <= RST_WORD;
      spare <= RST_WORD;
      maint_reg_three <= RST_WORD;
    end else if (reg_wr) begin
      case (reg_addr)
        REG_DCYL: desired_cylinder_reg <= reg_wdata;
        REG_DTRK: disk_track_sector_reg <= reg_wdata;
        REG_SPARE: spare <= reg_wdata;
        REG_MAINT3: maint_reg_three <= reg_wdata;
        default: ;
      endcase
    end
  end

  // the function and unit fields latch with every go write taken in idle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cmd_fn <= '0;
      cmd_unit <= 1'b0;
    end else if (cmd_start) begin
      cmd_fn <= wfn;
      cmd_unit <= reg_wdata[CMD_UNIT_BIT];
    end
  end

  // the arm is single use: any command start consumes it
  always_ff @(posedge core_clk) begin
    if (srst || ctl_clr) begin
      ext_en <= 1'b0;
    end else if (cmd_start) begin
      ext_en <= 1'b0;
    end else if (reg_wr && (reg_addr == REG_MAINT3) &&
                 reg_wdata == MAINT3_KEY && spare[SPARE_KEY_HI] &&
                 !spare[SPARE_KEY_LO]) begin
      ext_en <= 1'b1;
    end
  end

  // lock flags and switch register load together on write protect
  always_ff @(posedge core_clk) begin
    if (srst) begin
      lock <= '0;
      switch_reg <= '0;
    end else if (run_wp) begin
      lock <= spare[7:0];
      switch_reg <= spare[SW_MSB:SW_LSB];
    end
  end

  // a mapped unit's own protect overrides a clear lock flag
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      drive_protected[i] = lock[i] || wp_s[on_unit1[i]];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // command sequencer
  logic [7:0] dump_idx;
  logic [2:0] revs;
  logic [1:0] hdr_word;
  logic [2:0] rev_limit;
  logic set_srch;
  logic wrh_pop;
  logic [DATA_W-1:0] dump_word;

  // write check and the short switch both cut the search to one turn
  assign rev_limit = (cmd_fn == FN_WRITE_CHECK || switch_reg[ONE_REV_SW])
                     ? REVS_SHORT : REVS_NORMAL;
  assign set_srch = (state == ST_SEARCH) && idx_edge &&
                    (revs + 3'd1 == rev_limit);
  assign wrh_pop = (state == ST_WRH) && stb_edge && !silo.empty;

  // state image presented to the silo for diagnostics
  always_comb begin
    case (dump_idx)
      8'h00: dump_word = {7'h00, cmd_unit, !cmd_busy, 1'b0, cmd_fn, 1'b0};
      8'h01: dump_word = {14'h0000, search_err, illegal_function_err};
      8'h02: dump_word = desired_cylinder_reg;
      8'h03: dump_word = disk_track_sector_reg;
      8'h04: dump_word = spare;
      8'h05: dump_word = {2'h0, switch_reg, lock};
      8'h06: dump_word = {present, on_unit1};
      8'h07: dump_word = {4'h0, sec_unit1, sec_unit0};
      8'h08: dump_word = {8'h00, bank_s};
      default: dump_word = RST_WORD;
    endcase
  end

  // sequencer; header reads and writes start only after an index edge, a search does not wait for one
  always_ff @(posedge core_clk) begin
    if (srst || ctl_clr) begin
      state <= ST_IDLE;
      dump_idx <= '0;
      revs <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          dump_idx <= '0;
          revs <= '0;
          if (run_ext) begin
            case (wfn)
              FN_WRITE_PROTECT: state <= ST_DUMP;
              FN_READ_UNIT_HDR: state <= ST_RDH_WAIT;
              default: state <= ST_WRH_WAIT;
            endcase
          end else if (cmd_start && !is_ext &&
                       wfn >= FN_READ_DATA && wfn <= FN_WRITE_CHECK) begin
            state <= ST_SEARCH;
          end
        end
        ST_DUMP: begin
          dump_idx <= dump_idx + 8'h01;
          if (dump_idx == DUMP_WORDS - 8'h01) begin
            state <= ST_IDLE;
          end
        end
        ST_SEARCH: begin
          if (stb_edge && hdr_word == 2'd0 &&
              hdr_s == desired_cylinder_reg) begin
            state <= ST_IDLE;
          end else if (set_srch) begin
            state <= ST_IDLE;
          end else if (idx_edge) begin
            revs <= revs + 3'd1;
          end
        end
        ST_RDH_WAIT: if (idx_edge) begin
          state <= ST_RDH;
        end
        ST_RDH: if (idx_edge) begin
          state <= ST_IDLE;
        end
        ST_WRH_WAIT: if (idx_edge) begin
          state <= ST_WRH;
        end
        ST_WRH: if (idx_edge || (stb_edge && silo.empty)) begin
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // word position within a header, realigned at every index
  always_ff @(posedge core_clk) begin
    if (srst || idx_edge) begin
      hdr_word <= '0;
    end else if (stb_edge) begin
      hdr_word <= (hdr_word == 2'd2) ? 2'd0 : hdr_word + 2'd1;
    end
  end

  // error flags; a new event wins over a same-cycle error register clear, the control clear wins over both
  always_ff @(posedge core_clk) begin
    if (srst || ctl_clr) begin
      illegal_function_err <= 1'b0;
      search_err <= 1'b0;
    end else begin
      illegal_function_err <= (cmd_start && is_ext && !ext_en) ||
        (illegal_function_err && !(reg_wr && reg_addr == REG_ERR &&
         reg_wdata[ERR_ILF_BIT]));
      search_err <= set_srch || (search_err && !(reg_wr &&
        reg_addr == REG_ERR && reg_wdata[ERR_SRCH_BIT]));
    end
  end

  // header writer drives one silo word per header slot on the track
  always_ff @(posedge core_clk) begin
    if (srst) begin
      hdr_wr_en <= 1'b0;
      hdr_wr_data <= RST_WORD;
    end else begin
      hdr_wr_en <= (state == ST_WRH) && !(idx_edge || (stb_edge &&
                    silo.empty)) || (state == ST_WRH_WAIT && idx_edge);
      if (wrh_pop) begin
        hdr_wr_data <= silo.head;
      end
    end
  end

  // physical address comes straight from the software registers
  assign seek_cylinder = desired_cylinder_reg;
  assign seek_track = disk_track_sector_reg[TRK_MSB:0];
  assign unit_select = cmd_unit;

  ////////////////////////////////////////////////////////////////////////
  // silo traffic and read-back
  logic reg_pop;

  // a read outside the header write state pops in the same cycle it samples the head
  assign reg_pop = reg_rd && (reg_addr == REG_SILO) && (state != ST_WRH);
  assign silo.pop = reg_pop || wrh_pop;
  assign silo.clear = run_ext && (wfn != FN_WRITE_UNIT_HDR);
  // track order is taken as it passes under the head: interlace is kept
  assign silo.push = (state == ST_DUMP) ||
                     (state == ST_RDH && stb_edge && !idx_edge) ||
                     (reg_wr && reg_addr == REG_SILO && state == ST_IDLE);
  assign silo.push_data = (state == ST_DUMP) ? dump_word :
                          (state == ST_RDH) ? hdr_s : reg_wdata;

  // read data are registered and stand in the following cycle only
  always_ff @(posedge core_clk) begin
    if (srst) begin
      reg_rdata <= RST_WORD;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_CMD: reg_rdata <= {7'h00, cmd_unit, !cmd_busy, 1'b0,
                               cmd_fn, 1'b0};
        REG_ERR: reg_rdata <= {14'h0000, search_err, illegal_function_err};
        REG_DCYL: reg_rdata <= desired_cylinder_reg;
        REG_DTRK: reg_rdata <= disk_track_sector_reg;
        REG_SPARE: reg_rdata <= spare;
        REG_SILO: reg_rdata <= silo.empty ? RST_WORD : silo.head;
        REG_MAINT3: reg_rdata <= maint_reg_three;
        REG_STAT: reg_rdata <= {ext_en, 1'b0, switch_reg, drive_protected};
        default: reg_rdata <= RST_WORD;
      endcase
    end else begin
      reg_rdata <= RST_WORD;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  a_lock_load: assert property (run_wp |=> lock == $past(spare[7:0]))
    else $error("lock flags not loaded from spare");
  a_switch_save: assert property (
    run_wp |=> switch_reg == $past(spare[SW_MSB:SW_LSB]))
    else $error("switch register not saved");
  a_lock_protects: assert property (&(drive_protected | ~lock))
    else $error("locked drive not protected");
  a_unit_protects: assert property (
    run_wp && !ctl_clr ##1 (wp_s == 2'b00) |-> drive_protected == lock)
    else $error("protect differs from lock flags");
  a_dump_length: assert property (
    (state == ST_DUMP && dump_idx == 8'hFE) |=>
      state == ST_IDLE && silo.count == 9'd255)
    else $error("dump did not leave 255 words");
  a_short_search: assert property (
    state == ST_SEARCH && switch_reg[ONE_REV_SW] && idx_edge && !stb_edge
    |=> state == ST_IDLE)
    else $error("search ran past one revolution");
  a_long_search: assert property (
    state == ST_SEARCH && rev_limit == REVS_NORMAL && revs < 3'd3 &&
    idx_edge && !ctl_clr |=> state == ST_SEARCH)
    else $error("search ended before four revolutions");
  a_hdr_start: assert property (
    state == ST_RDH_WAIT && idx_edge && !ctl_clr |=> state == ST_RDH)
    else $error("header read did not start at index");
  a_arm_drop: assert property (cmd_start |=> !ext_en)
    else $error("arm survived a command");
  a_ilf_set: assert property (
    cmd_start && is_ext && !ext_en && !ctl_clr |=>
      illegal_function_err && state == ST_IDLE)
    else $error("unarmed extended code not refused");
  a_silo_read: assert property (
    reg_pop && !silo.empty |=> reg_rdata == $past(silo.head))
    else $error("silo read returned wrong word");
endmodule
`default_nettype wire

// ===== src/edcu_pkg.sv
package edcu_pkg;
  // register port geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  // register word offsets
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_ERR = 4'h1;
  localparam logic [3:0] REG_DCYL = 4'h2;
  localparam logic [3:0] REG_DTRK = 4'h3;
  localparam logic [3:0] REG_SPARE = 4'h4;
  localparam logic [3:0] REG_SILO = 4'h5;
  localparam logic [3:0] REG_MAINT3 = 4'h6;
  localparam logic [3:0] REG_STAT = 4'h7;
  localparam logic [3:0] REG_CTRL = 4'h8;
  // command register fields
  localparam int CMD_GO_BIT = 0;
  localparam int CMD_FN_LSB = 1;
  localparam int CMD_FN_MSB = 5;
  localparam int CMD_RDY_BIT = 7;
  localparam int CMD_UNIT_BIT = 8;
  // error register fields
  localparam int ERR_ILF_BIT = 0;
  localparam int ERR_SRCH_BIT = 1;
  // spare register fields, then the switch register bit and the track field top
  localparam int SPARE_KEY_HI = 15;
  localparam int SPARE_KEY_LO = 14;
  localparam int SW_LSB = 8;
  localparam int SW_MSB = 13;
  localparam int ONE_REV_SW = 1;
  localparam int TRK_MSB = 9;
  // control register fields
  localparam int CTRL_CLR_BIT = 0;
  // maintenance key and reset value
  localparam logic [15:0] MAINT3_KEY = 16'hFFFF;
  localparam logic [15:0] RST_WORD = 16'h0000;
  // function codes (command code without the go bit)
  localparam logic [4:0] FN_READ_DATA = 5'h08;
  localparam logic [4:0] FN_WRITE_CHECK = 5'h0C;
  localparam logic [4:0] FN_WRITE_PROTECT = 5'h0D;
  localparam logic [4:0] FN_READ_UNIT_HDR = 5'h0E;
  localparam logic [4:0] FN_WRITE_UNIT_HDR = 5'h0F;
  // counts
  localparam logic [7:0] DUMP_WORDS = 8'hFF;
  localparam logic [2:0] REVS_NORMAL = 3'h4;
  localparam logic [2:0] REVS_SHORT = 3'h1;
  localparam int SILO_DEPTH = 256;
  // command sequencer states, gray in the order listed
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DUMP = 3'b001,
    ST_SEARCH = 3'b011,
    ST_RDH_WAIT = 3'b010,
    ST_RDH = 3'b110,
    ST_WRH_WAIT = 3'b111,
    ST_WRH = 3'b101
  } state_t;
endpackage

// ===== src/silo_if.sv
`timescale 1ns/1ps
`default_nettype none
interface silo_if #(parameter int W = 16, parameter int CW = 9);
  logic push;
  logic pop;
  logic clear;
  logic [W-1:0] push_data;
  logic [W-1:0] head;
  logic empty;
  logic full;
  logic [CW-1:0] count;
  modport store (input push, pop, clear, push_data,
                 output head, empty, full, count);
  modport user (output push, pop, clear, push_data,
                input head, empty, full, count);
endinterface
`default_nettype wire

// ===== src/silo_store.sv
`timescale 1ns/1ps
`default_nettype none
module silo_store
  import edcu_pkg::*;
#(
  parameter int DEPTH = SILO_DEPTH,
  parameter int W = DATA_W
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // queue side
  silo_if.store s
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wptr;
  logic [PW-1:0] rptr;
  logic do_push;
  logic do_pop;

  // push into a full silo is dropped rather than overwriting the head
  assign do_push = s.push && !s.full;
  assign do_pop = s.pop && !s.empty;
  assign s.empty = (s.count == '0);
  assign s.full = (s.count == ($bits(s.count))'(DEPTH));
  assign s.head = mem[rptr];

  // word storage, no reset needed on data
  always_ff @(posedge core_clk) begin
    if (do_push) begin
      mem[wptr] <= s.push_data;
    end
  end

  // pointers and fill level; words leave in the order loaded
  always_ff @(posedge core_clk) begin
    if (srst || s.clear) begin
      wptr <= '0;
      rptr <= '0;
      s.count <= '0;
    end else begin
      if (do_push) begin
        wptr <= wptr + 1'b1;
      end
      if (do_pop) begin
        rptr <= rptr + 1'b1;
      end
      if (do_push && !do_pop) begin
        s.count <= s.count + 1'b1;
      end else if (do_pop && !do_push) begin
        s.count <= s.count - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== src/drive_config_map.sv
`timescale 1ns/1ps
`default_nettype none
module drive_config_map
  import edcu_pkg::*;
(
  // switch bank, already synchronised
  input wire logic [7:0] bank,
  // per logical drive placement
  output logic [7:0] present,
  output logic [7:0] on_unit1,
  // sectors per track of each port
  output logic [5:0] sec_unit0,
  output logic [5:0] sec_unit1
);
  // bank[5:0] selects the row, bank[7] the variant of rows 0 and 31; bank[6] is not decoded
  function automatic logic [27:0] row(input logic [7:0] p,
                                      input logic [7:0] u1,
                                      input logic [5:0] s0,
                                      input logic [5:0] s1);
    row = {p, u1, s0, s1};
  endfunction

  logic [27:0] sel;

  // only a subset of rows is decoded; others fall back to the 4+4 split
  always_comb begin
    sel = row(8'hFF, 8'hF0, 6'd35, 6'd35);
    case (bank[5:0])
      6'd0: sel = bank[7] ? row(8'hFF, 8'hC0, 6'd35, 6'd35)
                          : row(8'hFF, 8'hF0, 6'd35, 6'd35);
      6'd1: sel = row(8'h3F, 8'h30, 6'd35, 6'd35);
      6'd4: sel = row(8'hFF, 8'hC0, 6'd33, 6'd33);
      6'd7: sel = row(8'h03, 8'h02, 6'd23, 6'd23);
      6'd11: sel = row(8'h07, 8'h06, 6'd19, 6'd19);
      6'd14: sel = row(8'hFF, 8'hF0, 6'd33, 6'd33);
      6'd31: sel = bank[7] ? row(8'h0F, 8'h0C, 6'd23, 6'd23)
                           : row(8'hFF, 8'hF0, 6'd35, 6'd35);
      default: sel = row(8'hFF, 8'hF0, 6'd35, 6'd35);
    endcase
  end

  assign present = sel[27:20];
  assign on_unit1 = sel[19:12];
  assign sec_unit0 = sel[11:6];
  assign sec_unit1 = sel[5:0];
endmodule
`default_nettype wire

// ===== verification/disk_drive_model.sv
`timescale 1ns/1ps
`default_nettype none
module disk_drive_model #(
  parameter int HDRS = 5
) (
  // clock
  input wire logic core_clk,
  // track signals towards the controller
  output logic index_pulse,
  output logic hdr_rd_strobe,
  output logic [15:0] hdr_rd_data
);
  ////////////////////////////////////////////////////////////////////////////
  // header word j of a revolution: three words per header, sectors interlaced
  function automatic logic [15:0] hdr_word(input int j);
    return 16'h1000 * 16'(j % 3 + 1) + 16'((j / 3 * 2) % HDRS);
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // free running track: index, then strobed header words; between slots the
  // data lines toggle so a stale word never looks valid
  initial begin
    index_pulse = 1'b0;
    hdr_rd_strobe = 1'b0;
    hdr_rd_data = 16'h0000;
    forever begin
      @(posedge core_clk) index_pulse <= 1'b1;
      repeat (4) @(posedge core_clk);
      index_pulse <= 1'b0;
      for (int j = 0; j < 3 * HDRS; j++) begin
        repeat (2) begin
          @(posedge core_clk) hdr_rd_data <= ~hdr_rd_data;
        end
        @(posedge core_clk) hdr_rd_data <= hdr_word(j);
        repeat (2) @(posedge core_clk);
        hdr_rd_strobe <= 1'b1;
        repeat (4) @(posedge core_clk);
        hdr_rd_strobe <= 1'b0;
        repeat (2) @(posedge core_clk);
      end
    end
  end
endmodule
`default_nettype wire

// ===== verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import edcu_pkg::*;
  localparam int HDRS = 5;
  localparam int REV = 5 + 33 * HDRS; // cycles per model revolution
  ////////////////////////////////////////////////////////////////////////////
  // stimulus and observed signals
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, rd_q = 1'b0, wr_seen = 1'b0;
  logic [1:0] uwp = 2'b00;
  logic [7:0] bank = 8'h00;
  logic [DATA_W-1:0] reg_rdata, hdr_wr_data, seek_cylinder, hdr_rd_data;
  logic [DATA_W-1:0] last_wr = '0;
  logic [TRK_MSB:0] seek_track;
  logic [7:0] drive_protected;
  logic index_pulse, hdr_rd_strobe, hdr_wr_en, unit_select, cmd_busy;
  logic [15:0] exp_q[$];
  logic [15:0] mask_q[$];
  int failures = 0;
  int n_checks = 0;
  always #4 core_clk = ~core_clk;
  extended_disk_command_unit extended_disk_command_unit_inst (
    .core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .config_switch_bank(bank),
    .unit_write_protect(uwp), .index_pulse(index_pulse),
    .hdr_rd_strobe(hdr_rd_strobe), .hdr_rd_data(hdr_rd_data),
    .hdr_wr_en(hdr_wr_en), .hdr_wr_data(hdr_wr_data),
    .seek_cylinder(seek_cylinder), .seek_track(seek_track),
    .unit_select(unit_select), .drive_protected(drive_protected),
    .cmd_busy(cmd_busy));
  disk_drive_model #(.HDRS(HDRS)) disk_drive_model_inst (
    .core_clk(core_clk), .index_pulse(index_pulse),
    .hdr_rd_strobe(hdr_rd_strobe), .hdr_rd_data(hdr_rd_data));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk_word(input string what, input logic [15:0] e, g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s exp %h got %h", what, e, g);
    end
  endtask
  task automatic chk_flag(input string what, input logic e, g);
    chk_word(what, {15'h0000, e}, {15'h0000, g});
  endtask
  task automatic report_and_stop();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // a read leaves its expectation behind for the monitor below
  task automatic rd(input logic [3:0] a, input logic [15:0] e, m);
    exp_q.push_back(e & m);
    mask_q.push_back(m);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
  endtask
  // busy only shows one edge after the go write, so never look at once
  task automatic wait_idle(output int n);
    n = 1;
    @(posedge core_clk);
    while (cmd_busy !== 1'b0 && n < 4000) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 4000) chk_flag("busy", 1'b0, 1'b1);
  endtask
  task automatic arm_cmd(input logic [15:0] spare, cmd);
    wr(REG_SPARE, spare);
    wr(REG_MAINT3, MAINT3_KEY);
    wr(REG_CMD, cmd);
  endtask
  function automatic logic [15:0] cmdw(input logic [4:0] fn);
    return {10'h000, fn, 1'b1};
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // read data stand only in the cycle after the strobe, so look mid-cycle
  always @(posedge core_clk) rd_q <= reg_rd;
  always @(posedge core_clk) if (hdr_wr_en === 1'b1) begin
    wr_seen <= 1'b1;
    last_wr <= hdr_wr_data;
  end
  always @(negedge core_clk) if (rd_q) begin
    chk_word("rdata", exp_q.pop_front(), reg_rdata & mask_q.pop_front());
  end
  // watchdog, sized well past the longest expected run
  initial begin
    repeat (30000) @(posedge core_clk);
    failures++;
    report_and_stop();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int n;
    logic [7:0] lock;
    logic [5:0] sw;
    logic [15:0] spare;
    logic [15:0] w[3];
    void'($urandom(32'hcaef));
    repeat (8) @(posedge core_clk);
    srst <= 1'b0;
    repeat (4) @(posedge core_clk);
    rd(4'hF, 16'h0000, 16'hFFFF);
    for (int i = 0; i < 3; i++) begin
      wr(REG_ERR, 16'h0003);
      wr(REG_CMD, cmdw(FN_WRITE_PROTECT + 5'(i)));
      rd(REG_ERR, 16'h0001, 16'h0001);
    end
    $display("test unarmed done");
    lock = 8'($urandom);
    sw = 6'($urandom);
    spare = {2'b10, sw, lock};
    uwp <= 2'b10;
    arm_cmd(spare, cmdw(FN_WRITE_PROTECT));
    wait_idle(n);
    chk_word("prot", {8'h00, lock | 8'hF0}, {8'h00, drive_protected});
    uwp <= 2'b00;
    repeat (5) @(posedge core_clk);
    chk_word("unprot", {8'h00, lock}, {8'h00, drive_protected});
    rd(REG_STAT, {2'b00, sw, lock}, 16'hFFFF);
    for (int j = 0; j < 255; j++)
      rd(REG_SILO, j == 0 ? 16'h001A : j == 1 ? 16'h0001 : j == 4 ? spare :
         j == 5 ? {2'b00, sw, lock} : j == 6 ? 16'hFFF0 :
         j == 7 ? 16'h08E3 : j == 8 ? {8'h00, bank} : 16'h0000,
         16'hFFFF);
    rd(REG_SILO, 16'h0000, 16'hFFFF);
    wr(REG_ERR, 16'h0003);
    wr(REG_CMD, cmdw(FN_WRITE_PROTECT));
    rd(REG_ERR, 16'h0001, 16'h0001);
    $display("test write_protect done");
    wr(REG_DCYL, 16'h0123);
    wr(REG_DTRK, 16'h0002);
    arm_cmd(16'h8000, cmdw(FN_READ_UNIT_HDR));
    wait_idle(n);
    for (int j = 0; j < 3 * HDRS; j++)
      rd(REG_SILO, disk_drive_model_inst.hdr_word(j), 16'hFFFF);
    rd(REG_SILO, 16'h0000, 16'hFFFF);
    $display("test read_headers done");
    w[0] = 16'h0123;
    w[1] = 16'h3405;
    w[2] = w[0] ^ w[1];
    for (int i = 0; i < 3; i++) wr(REG_SILO, w[i]);
    wr(REG_DTRK, 16'h0005);
    arm_cmd(16'h8000, 16'h0100 | cmdw(FN_WRITE_UNIT_HDR));
    wait_idle(n);
    chk_flag("wr_gate", 1'b1, wr_seen);
    chk_word("wr_last", w[2], last_wr);
    chk_word("track", 16'h0005, {6'h00, seek_track});
    chk_word("cyl", 16'h0123, seek_cylinder);
    chk_flag("unit", 1'b1, unit_select);
    $display("test write_headers done");
    for (int k = 0; k < 3; k++) begin
      arm_cmd({2'b10, k == 0 ? 6'h02 : 6'h00, 8'h00}, cmdw(FN_WRITE_PROTECT));
      wait_idle(n);
      wr(REG_ERR, 16'h0003);
      wr(REG_DCYL, 16'h0000);
      wr(REG_CMD, cmdw(k == 1 ? FN_WRITE_CHECK : FN_READ_DATA));
      wait_idle(n);
      chk_flag("short", k != 2, n < 2 * REV);
      rd(REG_ERR, 16'h0002, 16'h0002);
    end
    $display("test search done");
    repeat (4) @(posedge core_clk);
    report_and_stop();
  end
endmodule
`default_nettype wire
